// ===== include/radio_pm_pkg.sv
// Purpose: Shared constants and types for the radio power mode and symbol map block
// Assumes: 25 MHz system clock, 32-bit register port with byte offsets
// Notes: Register offsets other than the mode selector are placed by this block
package radio_pm_pkg;

  // ==========================================================
  // Register port and map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_MODCFG = 8'h04;
  localparam logic [7:0] OFS_GAIN = 8'h08;
  localparam logic [7:0] OFS_RSSI = 8'h0C;
  localparam logic [7:0] OFS_AMPL = 8'h10;
  localparam logic [7:0] OFS_TRK = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;

  // ==========================================================
  // Power mode selector codes
  typedef enum logic [3:0] {
    PM_POWER_OFF_RETAIN_REGS = 4'h0,
    PM_FULL_OFF = 4'h1,
    PM_STANDBY = 4'h5,
    PM_BUFFER_ONLY = 4'h6,
    PM_SYNTH_SETTLE_RECEIVE = 4'h8,
    PM_RECEIVE_ACTIVE = 4'h9,
    PM_WAKE_ON_RADIO = 4'hB,
    PM_SYNTH_SETTLE_TRANSMIT = 4'hC,
    PM_TRANSMIT_ACTIVE = 4'hD
  } pmode_t;
  localparam logic [3:0] MODE_RESET = 4'h0;

  // ==========================================================
  // Modulation configuration fields
  typedef enum logic [1:0] {SCH_ASK = 2'h0, SCH_FSK = 2'h1, SCH_PSK = 2'h2, SCH_FSK4 = 2'h3} scheme_t;
  typedef enum logic [1:0] {FSH_HARD = 2'h0, FSH_GAUSS_BT03 = 2'h1, FSH_GAUSS_BT05 = 2'h2} fshape_t;
  localparam int MC_SCHEME_LSB = 0;
  localparam int MC_FSHAPE_LSB = 2;
  localparam int MC_ASHAPE_BIT = 4;
  localparam logic [4:0] MODCFG_RESET = 5'h10;

  // Status fields
  localparam int ST_APPLIED_LSB = 0;
  localparam int ST_PENDING_BIT = 4;
  localparam int ST_XTAL_OK_BIT = 5;
  localparam int ST_GAIN_VALID_BIT = 6;
  localparam int ST_TX_REFUSED_BIT = 8;
  localparam int ST_RESERVED_BIT = 9;

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 25000000;
  localparam int CLK_MHZ = 25;
  localparam int XTAL_SETTLE_US = 3000;
  localparam logic [16:0] XTAL_SETTLE_CYC = 17'(XTAL_SETTLE_US * CLK_MHZ);
  localparam int MAX_BIT_RATE_BPS = 125000;
  localparam logic [7:0] MIN_BIT_CYC = 8'((CLK_HZ + MAX_BIT_RATE_BPS - 1) / MAX_BIT_RATE_BPS);
  localparam logic [7:0] WAKE_INIT_CYC = 8'h20;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic core_supply;
    logic xtal;
    logic reference;
    logic synth;
    logic synth_tx_freq;
    logic receiver;
    logic transmitter;
    logic lp_osc;
    logic buffer_access;
  } radio_enables_t;

  typedef struct packed {
    logic [7:0] gain;
    logic [7:0] rssi;
    logic [15:0] ampl;
    logic [31:0] trk;
  } measure_t;

  typedef struct packed {
    logic pa_on;
    logic phase_180;
    logic [2:0] freq_step;
    logic amp_shape;
    fshape_t freq_shape;
  } symbol_t;

endpackage : radio_pm_pkg

// ===== logic/radio_power_mode_and_symbol_map.sv
// Purpose: Transceiver power mode sequencing, wake handshake, symbol mapping and readouts
// Assumes: All inputs synchronous to sys_clk; analog front end supplies raw measurements
// Notes: Register port answers every read one cycle later, unmapped reads give zero
`timescale 1ns/1ps
`default_nettype none

module radio_power_mode_and_symbol_map #(
  parameter logic [16:0] XTAL_SETTLE_CYCLES = radio_pm_pkg::XTAL_SETTLE_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port
  input wire logic [radio_pm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [radio_pm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [radio_pm_pkg::DATA_W-1:0] reg_rdata,
  // Front end status and measurements
  input wire logic synth_programmed,
  input wire logic synth_locked,
  input wire logic buffer_empty,
  input wire radio_pm_pkg::measure_t meas,
  // Wake pins
  input wire logic wake_sel_n,
  output logic miso_o,
  output logic miso_oe,
  // Section enables
  output radio_pm_pkg::radio_enables_t enables,
  output logic buffer_flush,
  // Transmit bit stream and symbol
  input wire logic tx_bit_valid,
  input wire logic [1:0] tx_bits,
  output logic tx_bit_ready,
  output radio_pm_pkg::symbol_t symbol
);
  import radio_pm_pkg::*;

  typedef enum logic [2:0] {WK_RUN = 3'b001, WK_ASLEEP = 3'b010, WK_INIT = 3'b100} wake_t;

  // ==========================================================
  // Decode helpers
  function automatic logic valid_mode(input logic [3:0] m);
    case (m)
      PM_POWER_OFF_RETAIN_REGS, PM_FULL_OFF, PM_STANDBY, PM_BUFFER_ONLY,
      PM_SYNTH_SETTLE_RECEIVE, PM_RECEIVE_ACTIVE, PM_WAKE_ON_RADIO,
      PM_SYNTH_SETTLE_TRANSMIT, PM_TRANSMIT_ACTIVE: valid_mode = 1'b1;
      default: valid_mode = 1'b0;
    endcase
  endfunction : valid_mode

  // Modes that drop the buffer, except full off, only start once it has drained
  function automatic logic needs_empty(input logic [3:0] m);
    needs_empty = (m == PM_POWER_OFF_RETAIN_REGS) || (m == PM_STANDBY) || (m == PM_WAKE_ON_RADIO);
  endfunction : needs_empty

  function automatic radio_enables_t decode_enables(input logic [3:0] m);
    radio_enables_t e;
    e = '0;
    case (m)
      PM_WAKE_ON_RADIO: e.lp_osc = 1'b1;
      PM_STANDBY:
      begin
        e.core_supply = 1'b1;
        e.xtal = 1'b1;
        e.reference = 1'b1;
      end
      PM_BUFFER_ONLY:
      begin
        e.core_supply = 1'b1;
        e.reference = 1'b1;
        e.buffer_access = 1'b1;
      end
      PM_SYNTH_SETTLE_RECEIVE, PM_RECEIVE_ACTIVE, PM_SYNTH_SETTLE_TRANSMIT, PM_TRANSMIT_ACTIVE:
      begin
        e.core_supply = 1'b1;
        e.xtal = 1'b1;
        e.reference = 1'b1;
        e.synth = 1'b1;
        e.buffer_access = 1'b1;
        e.synth_tx_freq = m[2];
        e.receiver = (m == PM_RECEIVE_ACTIVE);
        e.transmitter = (m == PM_TRANSMIT_ACTIVE);
      end
      default: e = '0;
    endcase
    decode_enables = e;
  endfunction : decode_enables

  // ==========================================================
  // State
  logic [3:0] mode_req_r;
  logic [3:0] mode_app_r;
  radio_enables_t en_r;
  logic flush_r;
  logic [4:0] cfg_r;
  logic tx_refused_r;
  logic reserved_r;
  wake_t wk_r;
  logic [7:0] wk_cnt_r;
  logic [16:0] xtal_cnt_r;
  logic xtal_ok_r;
  logic gain_valid_r;
  measure_t meas_r;
  logic [7:0] gap_r;
  symbol_t sym_r;
  logic [DATA_W-1:0] rdata_r;

  logic live;
  logic mode_wr;
  logic cfg_wr;
  logic stat_wr;
  logic mode_ok;
  logic pending;
  logic accept;
  logic [3:0] wr_code;
  scheme_t scheme;
  radio_enables_t en_nxt;

  // Register port decode; nothing reaches the map while the core is off
  assign live = (wk_r == WK_RUN);
  assign mode_wr = live && reg_wr && (reg_addr == OFS_MODE);
  assign cfg_wr = live && reg_wr && (reg_addr == OFS_MODCFG);
  assign stat_wr = live && reg_wr && (reg_addr == OFS_STAT);
  assign wr_code = reg_wdata[3:0];
  assign pending = (mode_req_r != mode_app_r);
  assign scheme = scheme_t'(cfg_r[MC_SCHEME_LSB +: 2]);
  assign en_nxt = decode_enables(mode_app_r);

  // transmit only from a settled synthesizer
  assign mode_ok = valid_mode(wr_code) &&
    ((wr_code != PM_TRANSMIT_ACTIVE) || ((mode_app_r == PM_SYNTH_SETTLE_TRANSMIT) && synth_locked));

  // ==========================================================
  // Mode selector
  // accepted codes only, reserved ones leave the selector alone
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      mode_req_r <= MODE_RESET;
    else if (!live)
      mode_req_r <= MODE_RESET;
    else if (mode_wr && mode_ok)
      mode_req_r <= wr_code;
  end

  // buffer-dropping modes other than full off wait for an empty buffer
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      mode_app_r <= MODE_RESET;
    else if (wk_r == WK_ASLEEP)
      mode_app_r <= PM_FULL_OFF;
    else if (wk_r == WK_INIT)
      mode_app_r <= MODE_RESET;
    else if (pending && (!needs_empty(mode_req_r) || buffer_empty))
      mode_app_r <= mode_req_r;
  end

  // section enables follow the applied mode
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      en_r <= '0;
      flush_r <= 1'b0;
    end
    else
    begin
      en_r <= en_nxt;
      flush_r <= !en_nxt.buffer_access && en_r.buffer_access;
    end
  end

  // Sticky error flags; a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_refused_r <= 1'b0;
      reserved_r <= 1'b0;
    end
    else if (!live)
    begin
      tx_refused_r <= 1'b0;
      reserved_r <= 1'b0;
    end
    else
    begin
      tx_refused_r <= (mode_wr && valid_mode(wr_code) && !mode_ok) ||
        (tx_refused_r && !(stat_wr && reg_wdata[ST_TX_REFUSED_BIT]));
      reserved_r <= (mode_wr && !valid_mode(wr_code)) ||
        (reserved_r && !(stat_wr && reg_wdata[ST_RESERVED_BIT]));
    end
  end

  // ==========================================================
  // Full-off and wake handshake
  // full off drops mode, configuration, error flags and enables until the wake init count runs out; measurements are kept
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wk_r <= WK_RUN;
      wk_cnt_r <= 8'h00;
    end
    else
    begin
      case (wk_r)
        WK_RUN:
          if (mode_app_r == PM_FULL_OFF)
            wk_r <= WK_ASLEEP;
        WK_ASLEEP:
          if (!wake_sel_n)
          begin
            wk_r <= WK_INIT;
            wk_cnt_r <= WAKE_INIT_CYC - 8'h01;
          end
        WK_INIT:
          if (wk_cnt_r == 8'h00)
            wk_r <= WK_RUN;
          else
            wk_cnt_r <= wk_cnt_r - 8'h01;
        default: wk_r <= WK_RUN;
      endcase
    end
  end

  // MISO low through init, high when ready; released while asleep
  assign miso_oe = (wk_r == WK_INIT) || ((wk_r == WK_RUN) && !wake_sel_n);
  assign miso_o = (wk_r == WK_RUN);

  // ==========================================================
  // Crystal settling: the host may also just wait the typical figure
  // settle count runs while the crystal is powered
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      xtal_cnt_r <= 17'h00000;
      xtal_ok_r <= 1'b0;
    end
    else if (!en_r.xtal)
    begin
      xtal_cnt_r <= 17'h00000;
      xtal_ok_r <= 1'b0;
    end
    else if (xtal_cnt_r >= XTAL_SETTLE_CYCLES - 17'h00001)
      xtal_ok_r <= 1'b1;
    else
      xtal_cnt_r <= xtal_cnt_r + 17'h00001;
  end

  // ==========================================================
  // Measurements
  // gain counter live once the synthesizer is programmed
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meas_r.gain <= 8'h00;
      gain_valid_r <= 1'b0;
    end
    else
    begin
      gain_valid_r <= synth_programmed;
      if (synth_programmed)
        meas_r.gain <= meas.gain;
    end
  end

  // post-filter strength, amplitude and carrier offset while receiving
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meas_r.rssi <= 8'h00;
      meas_r.ampl <= 16'h0000;
      meas_r.trk <= 32'h00000000;
    end
    else if (en_r.receiver)
    begin
      meas_r.rssi <= meas.rssi;
      meas_r.ampl <= meas.ampl;
      meas_r.trk <= meas.trk;
    end
  end

  // ==========================================================
  // Modulator
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      cfg_r <= MODCFG_RESET;
    else if (!live)
      cfg_r <= MODCFG_RESET;
    else if (cfg_wr)
      cfg_r <= reg_wdata[4:0];
  end

  // bit period never shorter than the top rate allows
  assign accept = tx_bit_valid && tx_bit_ready;
  assign tx_bit_ready = en_r.transmitter && (gap_r == 8'h00);

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      gap_r <= 8'h00;
    else if (accept)
      gap_r <= MIN_BIT_CYC - 8'h01;
    else if (gap_r != 8'h00)
      gap_r <= gap_r - 8'h01;
  end

  // Symbol held until the next accepted bit; cleared when transmit stops
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      sym_r <= '0;
    else if (!en_r.transmitter)
      sym_r <= '0;
    else if (accept)
    begin
      // shaping applies to every scheme, so the amplifier ramps smoothly
      sym_r.amp_shape <= cfg_r[MC_ASHAPE_BIT];
      // reserved shaping code falls back to hard
      if (scheme == SCH_FSK4 || cfg_r[MC_FSHAPE_LSB +: 2] == 2'h3)
        sym_r.freq_shape <= FSH_HARD;
      else
        sym_r.freq_shape <= fshape_t'(cfg_r[MC_FSHAPE_LSB +: 2]);
      case (scheme)
        // binary schemes use the low bit
        SCH_ASK:
        begin
          sym_r.pa_on <= tx_bits[0];
          sym_r.phase_180 <= 1'b0;
          sym_r.freq_step <= 3'h0;
        end
        SCH_FSK:
        begin
          sym_r.pa_on <= 1'b1;
          sym_r.phase_180 <= 1'b0;
          sym_r.freq_step <= tx_bits[0] ? 3'h1 : 3'h7;
        end
        SCH_PSK:
        begin
          sym_r.pa_on <= 1'b1;
          sym_r.phase_180 <= tx_bits[0];
          sym_r.freq_step <= 3'h0;
        end
        SCH_FSK4:
        begin
          sym_r.pa_on <= 1'b1;
          sym_r.phase_180 <= 1'b0;
          case (tx_bits)
            2'h0: sym_r.freq_step <= 3'h5;
            2'h1: sym_r.freq_step <= 3'h7;
            2'h3: sym_r.freq_step <= 3'h1;
            default: sym_r.freq_step <= 3'h3;
          endcase
        end
        default: sym_r.pa_on <= 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Read port: data only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rdata_r <= '0;
    else if (!(reg_rd && live))
      rdata_r <= '0;
    else
    begin
      case (reg_addr)
        OFS_MODE: rdata_r <= {28'h0000000, mode_req_r};
        OFS_MODCFG: rdata_r <= {27'h0000000, cfg_r};
        OFS_GAIN: rdata_r <= {24'h000000, meas_r.gain};
        OFS_RSSI: rdata_r <= {24'h000000, meas_r.rssi};
        OFS_AMPL: rdata_r <= {16'h0000, meas_r.ampl};
        OFS_TRK: rdata_r <= meas_r.trk;
        OFS_STAT: rdata_r <= {22'h000000, reserved_r, tx_refused_r, 1'b0, gain_valid_r,
          xtal_ok_r, pending, mode_app_r};
        default: rdata_r <= '0;
      endcase
    end
  end

  assign reg_rdata = rdata_r;
  assign enables = en_r;
  assign buffer_flush = flush_r;
  assign symbol = sym_r;

  // ==========================================================
  // Assertions
  logic [7:0] since_acc_r;
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      since_acc_r <= 8'hFF;
    else if (accept)
      since_acc_r <= 8'h00;
    else if (since_acc_r != 8'hFF)
      since_acc_r <= since_acc_r + 8'h01;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_reserved_ignored;
    (mode_wr && !valid_mode(wr_code)) |=> (mode_req_r == $past(mode_req_r)) && reserved_r;
  endproperty
  a_reserved_ignored: assert property (p_reserved_ignored) else $error("reserved code taken");

  property p_tx_after_settle;
    (mode_app_r == PM_TRANSMIT_ACTIVE && $past(mode_app_r) != PM_TRANSMIT_ACTIVE)
      |-> $past(mode_app_r) == PM_SYNTH_SETTLE_TRANSMIT;
  endproperty
  a_tx_after_settle: assert property (p_tx_after_settle) else $error("transmit without settling");

  property p_empty_wait;
    (mode_app_r != $past(mode_app_r) && needs_empty(mode_app_r) && $past(live)) |-> $past(buffer_empty);
  endproperty
  a_empty_wait: assert property (p_empty_wait) else $error("mode entered with data buffered");

  property p_apply_quick;
    (live && pending && !needs_empty(mode_req_r) && !mode_wr) |=> !pending;
  endproperty
  a_apply_quick: assert property (p_apply_quick) else $error("mode not applied");

  property p_buffer_only;
    (mode_app_r == PM_BUFFER_ONLY) |=> en_r.buffer_access && en_r.reference && !en_r.transmitter;
  endproperty
  a_buffer_only: assert property (p_buffer_only) else $error("buffer mode enables wrong");

  property p_rx_enable;
    en_r.receiver |-> $past(mode_app_r) == PM_RECEIVE_ACTIVE;
  endproperty
  a_rx_enable: assert property (p_rx_enable) else $error("receiver on in wrong mode");

  property p_gain_track;
    synth_programmed |=> meas_r.gain == $past(meas.gain);
  endproperty
  a_gain_track: assert property (p_gain_track) else $error("gain counter stale");

  property p_fsk4_pair;
    (accept && scheme == SCH_FSK4 && tx_bits == 2'h2) |=> sym_r.freq_step == 3'h3 && sym_r.freq_shape == FSH_HARD;
  endproperty
  a_fsk4_pair: assert property (p_fsk4_pair) else $error("four-level map wrong");

  property p_bit_rate;
    accept |-> since_acc_r >= MIN_BIT_CYC - 8'h01;
  endproperty
  a_bit_rate: assert property (p_bit_rate) else $error("bits too close");

  property p_sleep_loss;
    (wk_r == WK_ASLEEP) |=> (mode_req_r == MODE_RESET) && (cfg_r == MODCFG_RESET) && (en_r == '0);
  endproperty
  a_sleep_loss: assert property (p_sleep_loss) else $error("state kept in full off");

  property p_wake_start;
    (wk_r == WK_ASLEEP && !wake_sel_n) |=> wk_r == WK_INIT ##1 (miso_oe && !miso_o) [*8];
  endproperty
  a_wake_start: assert property (p_wake_start) else $error("wake handshake wrong");

  property p_trk_hold;
    en_r.receiver |=> meas_r.trk == $past(meas.trk);
  endproperty
  a_trk_hold: assert property (p_trk_hold) else $error("offset not tracked");

  c_tx_session: cover property (mode_app_r == PM_SYNTH_SETTLE_TRANSMIT ##[1:20] mode_app_r == PM_TRANSMIT_ACTIVE);
  c_wake_done: cover property (wk_r == WK_INIT ##[1:40] wk_r == WK_RUN);
  c_fsk4_sym: cover property (accept && scheme == SCH_FSK4);
  c_tx_refused: cover property ($rose(tx_refused_r));

endmodule : radio_power_mode_and_symbol_map

`default_nettype wire

// ===== verif/host_wake_model.sv
// Purpose: Host side of the wake handshake out of full off
// Assumes: MISO is judged only while the device drives it
// Notes: Counts low MISO cycles so the bench can judge the init span
`timescale 1ns/1ps
`default_nettype none
module host_wake_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Bench control
  input wire logic go,
  output logic ready,
  output logic [7:0] low_cyc,
  // Device pins
  input wire logic miso_o,
  input wire logic miso_oe,
  output logic wake_sel_n
);
  // ==========================================
  // Wake handshake
  // select low, poll
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wake_sel_n <= 1'h1;
      ready <= 1'h0;
      low_cyc <= 8'h00;
    end
    else if (go)
    begin
      wake_sel_n <= 1'h0;
      ready <= 1'h0;
      low_cyc <= 8'h00;
    end
    else if (!wake_sel_n && miso_oe)
    begin
      // Release only after a low phase, so a stale high is not taken as ready
      if (!miso_o)
        low_cyc <= low_cyc + 8'h01;
      else if (low_cyc != 8'h00)
      begin
        ready <= 1'h1;
        wake_sel_n <= 1'h1;
      end
    end
  end
endmodule : host_wake_model
`default_nettype wire

// ===== verif/radio_power_mode_and_symbol_map_tb.sv
// Purpose: Self-checking bench for power modes, symbol map and readouts
// Assumes: Crystal settle shortened to 20 cycles
// Notes: Register tasks follow the one-cycle strobe port
`timescale 1ns/1ps
`default_nettype none
module radio_power_mode_and_symbol_map_tb;
  import radio_pm_pkg::*;
  logic sys_clk = 1'h0, resetn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, go = 1'h0;
  logic synth_programmed = 1'h0, synth_locked = 1'h0, buffer_empty = 1'h1, tx_bit_valid = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val, got;
  logic [1:0] tx_bits = 2'h0;
  measure_t meas = {8'h5A, 8'hA5, 16'h1234, 32'hCAFE0001};
  logic miso_o, miso_oe, buffer_flush, tx_bit_ready, wake_sel_n, ready;
  logic [7:0] low_cyc;
  radio_enables_t enables;
  symbol_t symbol;
  int err_total = 0, n_tests = 0, gap, n_flush = 0;
  logic [3:0] codes [6] = '{4'h5, 4'h6, 4'h8, 4'h9, 4'hB, 4'hC};
  logic [5:0] en_exp [6] = '{6'h00, 6'h01, 6'h20, 6'h28, 6'h02, 6'h30};
  logic [5:0] en_msk [6] = '{6'h3F, 6'h3F, 6'h3E, 6'h3E, 6'h3F, 6'h3E};
  logic [1:0] tb_bits [10] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h3, 2'h2};
  logic [2:0] tb_exp [10] = '{3'h0, 3'h1, 3'h7, 3'h1, 3'h0, 3'h1, 3'h5, 3'h7, 3'h1, 3'h3};
  logic [31:0] mc [4] = '{32'h10, 32'h15, 32'h12, 32'h17};
  wire logic [5:0] en_bits = {enables.synth, enables.synth_tx_freq, enables.receiver,
    enables.transmitter, enables.lp_osc, enables.buffer_access};

  // Clock, 40 ns period
  always #20 sys_clk = ~sys_clk;

  // Count buffer flush pulses; each stands for one cycle only
  always @(posedge sys_clk)
  begin
    if (buffer_flush === 1'h1)
      n_flush++;
  end

  radio_power_mode_and_symbol_map #(.XTAL_SETTLE_CYCLES(17'h14)) radio_power_mode_and_symbol_map_inst (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .synth_programmed(synth_programmed),
    .synth_locked(synth_locked), .buffer_empty(buffer_empty), .meas(meas), .wake_sel_n(wake_sel_n),
    .miso_o(miso_o), .miso_oe(miso_oe), .enables(enables), .buffer_flush(buffer_flush),
    .tx_bit_valid(tx_bit_valid), .tx_bits(tx_bits), .tx_bit_ready(tx_bit_ready), .symbol(symbol));

  host_wake_model host_wake_model_inst (.sys_clk(sys_clk), .resetn(resetn), .go(go), .ready(ready),
    .low_cyc(low_cyc), .miso_o(miso_o), .miso_oe(miso_oe), .wake_sel_n(wake_sel_n));

  // ==========================================
  // Shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  // Write, then wait until a mode change has reached the enables
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    @(negedge sys_clk);
    rd_val = reg_rdata;
  endtask : rd

  // Offer a bit and hold it until taken; gap counts the wait
  task automatic send(input logic [1:0] b);
    @(posedge sys_clk);
    tx_bits <= b;
    tx_bit_valid <= 1'h1;
    gap = 0;
    @(negedge sys_clk);
    while (tx_bit_ready !== 1'h1 && gap < 400)
    begin
      @(negedge sys_clk);
      gap++;
    end
    @(posedge sys_clk);
    tx_bit_valid <= 1'h0;
    @(negedge sys_clk);
  endtask : send

  task automatic t_end(input string s);
    $display("test %s done", s);
  endtask : t_end

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // Watchdog, far beyond the few thousand cycles the tests need
  initial
  begin
    #(40 * 30000);
    err_total++;
    final_report();
  end

  // ==========================================
  // Test sequence
  initial
  begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'h1;
    synth_programmed <= 1'h1;
    rd(OFS_MODE); chk(rd_val, 32'h0);
    rd(OFS_MODCFG); chk(rd_val, 32'h10);
    rd(8'h1C); chk(rd_val, 32'h0);
    rd(OFS_GAIN); chk(rd_val, 32'h5A);
    rd(OFS_STAT); chk(rd_val[6], 1'h1);
    t_end("reset");
    wr(OFS_MODE, 32'h3); rd(OFS_STAT); chk(rd_val & 32'h20F, 32'h200);
    wr(OFS_STAT, 32'h200); rd(OFS_STAT); chk(rd_val[9], 1'h0);
    t_end("reserved");
    for (int i = 0; i < 6; i++)
    begin
      wr(OFS_MODE, {28'h0, codes[i]}); rd(OFS_STAT); chk(rd_val[3:0], codes[i]);
      chk(en_bits & en_msk[i], en_exp[i] & en_msk[i]);
      if (i == 0)
      begin
        repeat (30) @(posedge sys_clk);
        rd(OFS_STAT); chk(rd_val[5], 1'h1);
        chk({enables.xtal, enables.reference}, 2'h3);
      end
      if (i == 3)
      begin
        rd(OFS_RSSI); chk(rd_val, 32'hA5);
        rd(OFS_AMPL); chk(rd_val, 32'h1234);
        rd(OFS_TRK); chk(rd_val, 32'hCAFE0001);
      end
    end
    t_end("modes");
    wr(OFS_MODE, 32'hD); rd(OFS_STAT); chk(rd_val & 32'h10F, 32'h10C);
    wr(OFS_STAT, 32'h100);
    @(posedge sys_clk);
    synth_locked <= 1'h1;
    wr(OFS_MODE, 32'hD); rd(OFS_STAT); chk(rd_val & 32'h10F, 32'h00D);
    chk(enables.transmitter, 1'h1);
    t_end("guard");
    for (int i = 0; i < 10; i++)
    begin
      if (i % 2 == 0 && i < 7)
        wr(OFS_MODCFG, mc[i / 2]);
      send(tb_bits[i]);
      got = (i < 2) ? symbol.pa_on : (i >= 4 && i < 6) ? symbol.phase_180 : symbol.freq_step;
      chk(got, tb_exp[i]);
      chk(symbol.amp_shape, 1'h1);
      if (i % 2 == 1)
        chk(gap >= 190, 1'h1);
      if (i == 2)
        chk(symbol.freq_shape, FSH_GAUSS_BT03);
    end
    chk(symbol.freq_shape, FSH_HARD);
    t_end("symbols");
    @(posedge sys_clk);
    buffer_empty <= 1'h0;
    wr(OFS_MODE, 32'h0); rd(OFS_STAT); chk(rd_val[4:0], 5'h1D);
    @(posedge sys_clk);
    buffer_empty <= 1'h1;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(enables.buffer_access, 1'h0);
    chk(n_flush, 32'h2);
    rd(OFS_STAT); chk(rd_val[4:0], 5'h00);
    t_end("buffer");
    wr(OFS_MODE, 32'h1); chk(enables, 9'h000);
    rd(OFS_MODCFG); chk(rd_val, 32'h0);
    @(posedge sys_clk);
    go <= 1'h1;
    @(posedge sys_clk);
    go <= 1'h0;
    for (int k = 0; k < 100 && ready !== 1'h1; k++)
      @(negedge sys_clk);
    chk(ready, 1'h1);
    chk(low_cyc, 32'h20);
    rd(OFS_MODCFG); chk(rd_val, 32'h10);
    rd(OFS_STAT); chk(rd_val[3:0], 4'h0);
    t_end("wake");
    final_report();
  end
endmodule : radio_power_mode_and_symbol_map_tb
`default_nettype wire
